/* File: hw/mpct_deadtime.sv */
`timescale 1ns/100ps
module mpct_deadtime #(
    parameter int DT_W = mpct_pkg::DT_W
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            ce,
    input  wire logic            ref_in,
    input  wire logic [DT_W-1:0] dead_time,
    input  wire logic            force_off,
    output logic                 out_hi,
    output logic                 out_lo
);
    typedef struct packed {
        logic            prev;
        logic [DT_W-1:0] cnt;
        logic            hi;
        logic            lo;
    } mpct_dt_state_t;

    mpct_dt_state_t st_reg;
    mpct_dt_state_t st_next;

    localparam logic [DT_W-1:0] DT_ZERO_L = '0;
    localparam logic [DT_W-1:0] DT_ONE_L  = DT_W'(1);

    // Both sides off while the gap counter runs, avoiding shoot-through
    always_comb begin
        st_next = st_reg;
        st_next.prev = ref_in;
        if (ref_in != st_reg.prev) begin
            st_next.cnt = dead_time;
            st_next.hi = 1'b0;
            st_next.lo = 1'b0;
        end else if (st_reg.cnt != DT_ZERO_L) begin
            st_next.cnt = st_reg.cnt - DT_ONE_L;
        end else begin
            st_next.hi = ref_in; // RULE4
            st_next.lo = ~ref_in; // RULE4
        end
        if (force_off) begin
            st_next.hi = 1'b0; // RULE6
            st_next.lo = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign out_hi = st_reg.hi;
    assign out_lo = st_reg.lo;

    property p_no_overlap;
        @(posedge clk) disable iff (!rst_b) !(out_hi && out_lo);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("pair overlap"); // RULE4

    property p_gap;
        @(posedge clk) disable iff (!rst_b)
            (ce && !force_off && ref_in != st_reg.prev) |=> (!out_hi && !out_lo);
    endproperty
    a_gap: assert property (p_gap) else $error("no dead gap"); // RULE4
endmodule

/* File: hw/mpct_pkg.sv */
package mpct_pkg;
    localparam int CNT_W   = 16;
    localparam int PSC_W   = 16;
    localparam int NCH     = 4;
    localparam int DT_W    = 8;
    localparam int MODE_W  = 2;
    localparam int CHM_W   = 3;
    localparam int HALL_W  = 3;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [PSC_W-1:0] PSC_ZERO = 16'h0000;
    localparam logic [PSC_W-1:0] PSC_ONE  = 16'h0001;
    localparam logic [DT_W-1:0]  DT_ZERO  = 8'h00;
    localparam logic [DT_W-1:0]  DT_ONE   = 8'h01;

    typedef enum logic [MODE_W-1:0] {
        MPCT_CNT_UP,
        MPCT_CNT_DOWN,
        MPCT_CNT_CENTER,
        MPCT_CNT_ENCODER
    } mpct_cnt_mode_t;

    typedef enum logic [CHM_W-1:0] {
        MPCT_CH_OFF,
        MPCT_CH_CAPTURE,
        MPCT_CH_COMPARE,
        MPCT_CH_PWM,
        MPCT_CH_ONEPULSE
    } mpct_ch_mode_t;

    typedef enum logic [1:0] {
        MPCT_VAR_BASIC,
        MPCT_VAR_GENERAL,
        MPCT_VAR_ADVANCED
    } mpct_variant_t;
endpackage

/* File: hw/mpct_timer.sv */
`timescale 1ns/100ps
//
// Function
// (RULE1) 16-bit counter, up, down or centre
// (RULE2) Prescaler divides by 1 to 65536
// (RULE3) Four channels: capture, compare, PWM, one-pulse
// (RULE4) Advanced: complementary pairs with dead-time
// (RULE5) PWM duty spans 0 to 100 percent
// (RULE6) Debug halt freezes counter, disables outputs (advanced variant only; general variant keeps driving ch_out)
// (RULE7) Trigger in/out links sibling timers
// (RULE8) DMA request on timer events
// (RULE9) Quadrature encoder and hall inputs
// (RULE10) Basic: up only, no channels, DAC trigger
// (RULE11) Overflow reloads, emits update event
module mpct_timer #(
    parameter mpct_pkg::mpct_variant_t VARIANT = mpct_pkg::MPCT_VAR_ADVANCED,
    parameter int CNT_W = mpct_pkg::CNT_W,
    parameter int NCH   = mpct_pkg::NCH,
    parameter int DT_W  = mpct_pkg::DT_W
) (
    input  wire logic                                 clk,
    input  wire logic                                 rst_b,
    input  wire logic                                 ce,
    input  wire logic                                 cnt_enable,
    input  wire mpct_pkg::mpct_cnt_mode_t             cnt_mode,
    input  wire logic [CNT_W-1:0]                     auto_reload,
    input  wire logic [mpct_pkg::PSC_W-1:0]           prescale,
    input  wire mpct_pkg::mpct_ch_mode_t [NCH-1:0]    ch_mode,
    input  wire logic [NCH-1:0][CNT_W-1:0]            ch_compare,
    input  wire logic [NCH-1:0]                       ch_pin_in,
    input  wire logic [DT_W-1:0]                      dead_time,
    input  wire logic                                 dbg_halt,
    input  wire logic                                 dbg_freeze_en,
    input  wire logic                                 link_trig_in,
    input  wire logic                                 link_clock_sel,
    input  wire logic                                 link_start_sel,
    input  wire logic                                 enc_a,
    input  wire logic                                 enc_b,
    input  wire logic [mpct_pkg::HALL_W-1:0]          hall_in,
    input  wire logic                                 hall_sel,
    output logic [CNT_W-1:0]                          count,
    output logic [NCH-1:0][CNT_W-1:0]                 ch_captured,
    output logic [NCH-1:0]                            ch_event,
    output logic [NCH-1:0]                            ch_out,
    output logic [NCH-2:0]                            ch_out_n,
    output logic                                      update_event,
    output logic                                      dma_req,
    output logic                                      link_trig_out,
    output logic                                      dac_trig
);
    localparam logic [CNT_W-1:0] C0 = CNT_W'(mpct_pkg::CNT_ZERO);
    localparam logic [CNT_W-1:0] C1 = CNT_W'(mpct_pkg::CNT_ONE);
    localparam bit HAS_CH  = (VARIANT != mpct_pkg::MPCT_VAR_BASIC);
    localparam bit HAS_CMP = (VARIANT == mpct_pkg::MPCT_VAR_ADVANCED);

    // Pins: 2-FF sync, first stage read only by the second
    typedef struct packed {
        logic [NCH-1:0]                 ch_s1;
        logic [NCH-1:0]                 ch_s2;
        logic [NCH-1:0]                 ch_prev;
        logic [1:0]                     enc_s1;
        logic [1:0]                     enc_s2;
        logic [1:0]                     enc_prev;
        logic [mpct_pkg::HALL_W-1:0]    hall_s1;
        logic [mpct_pkg::HALL_W-1:0]    hall_s2;
        logic [mpct_pkg::HALL_W-1:0]    hall_prev;
        logic                           trig_prev;
        logic                           started;
        logic [mpct_pkg::PSC_W-1:0]     psc_cnt;
        logic [CNT_W-1:0]               cnt;
        logic                           dir_down;
        logic [NCH-1:0]                 oc;
        logic [NCH-1:0]                 op_done;
        logic [NCH-1:0][CNT_W-1:0]      cap;
        logic [NCH-1:0]                 ev;
        logic                           upd;
    } mpct_state_t;

    mpct_state_t st_reg;
    mpct_state_t st_next;

    function automatic logic quad_step(input logic [1:0] p, input logic [1:0] c,
                                       output logic dn);
        logic moved;
        moved = (p != c);
        dn = (p[0] ^ c[1]);
        return moved && (p[0] ^ c[0]) != (p[1] ^ c[1]);
    endfunction

    logic halted;
    logic tick;
    logic enc_mv;
    logic enc_dn;
    logic hall_chg;
    logic run;
    logic at_top;
    logic at_bot;

    assign halted   = dbg_halt && dbg_freeze_en; // RULE6
    assign hall_chg = hall_sel && (st_reg.hall_prev != '0) // RULE9
                      && (st_reg.hall_s2 != st_reg.hall_prev);
    assign run      = cnt_enable && (st_reg.started || !link_start_sel) && !halted;
    assign at_top   = (st_reg.cnt == auto_reload);
    assign at_bot   = (st_reg.cnt == C0);

    always_comb begin
        st_next = st_reg;
        enc_dn = 1'b0;
        enc_mv = quad_step(st_reg.enc_prev, st_reg.enc_s2, enc_dn); // RULE9
        st_next.ch_s1 = ch_pin_in;
        st_next.ch_s2 = st_reg.ch_s1;
        st_next.ch_prev = st_reg.ch_s2;
        st_next.enc_s1 = {enc_b, enc_a};
        st_next.enc_s2 = st_reg.enc_s1;
        st_next.enc_prev = st_reg.enc_s2;
        st_next.hall_s1 = hall_in;
        st_next.hall_s2 = st_reg.hall_s1;
        st_next.hall_prev = st_reg.hall_s2;
        st_next.trig_prev = link_trig_in;
        st_next.ev = '0;
        st_next.upd = 1'b0;
        tick = 1'b0;
        if (link_start_sel && link_trig_in && !st_reg.trig_prev) begin
            st_next.started = 1'b1; // RULE7
        end
        if (!cnt_enable) begin
            st_next.started = 1'b0;
        end
        if (run) begin
            if (link_clock_sel) begin
                tick = link_trig_in && !st_reg.trig_prev; // RULE7
            end else if (st_reg.psc_cnt >= prescale) begin
                st_next.psc_cnt = mpct_pkg::PSC_ZERO; // RULE2
                tick = 1'b1;
            end else begin
                st_next.psc_cnt = st_reg.psc_cnt + mpct_pkg::PSC_ONE;
            end
        end
        // Basic variant ignores mode, always counts up
        if (!HAS_CH || cnt_mode == mpct_pkg::MPCT_CNT_UP) begin // RULE10
            if (tick) begin
                st_next.cnt = at_top ? C0 : st_reg.cnt + C1; // RULE1
                st_next.upd = at_top; // RULE11
            end
        end else if (cnt_mode == mpct_pkg::MPCT_CNT_DOWN) begin
            if (tick) begin
                st_next.cnt = at_bot ? auto_reload : st_reg.cnt - C1; // RULE11
                st_next.upd = at_bot;
            end
        end else if (cnt_mode == mpct_pkg::MPCT_CNT_CENTER) begin
            if (tick) begin
                if (!st_reg.dir_down && st_reg.cnt >= auto_reload) begin
                    st_next.dir_down = 1'b1; // RULE1
                    st_next.cnt = st_reg.cnt - C1;
                    st_next.upd = 1'b1;
                end else if (st_reg.dir_down && at_bot) begin
                    st_next.dir_down = 1'b0;
                    st_next.cnt = C1;
                    st_next.upd = 1'b1;
                end else begin
                    st_next.cnt = st_reg.dir_down ? st_reg.cnt - C1 : st_reg.cnt + C1;
                end
            end
        end else if (enc_mv && !halted && cnt_enable) begin
            st_next.dir_down = enc_dn;
            if (enc_dn) begin
                st_next.cnt = at_bot ? auto_reload : st_reg.cnt - C1; // RULE9
            end else begin
                st_next.cnt = at_top ? C0 : st_reg.cnt + C1;
            end
            st_next.upd = enc_dn ? at_bot : at_top;
        end
        for (int i = 0; i < NCH; i++) begin
            if (!HAS_CH) begin
                st_next.oc[i] = 1'b0;
            end else begin
                case (ch_mode[i])
                    mpct_pkg::MPCT_CH_CAPTURE: begin
                        if ((st_reg.ch_s2[i] && !st_reg.ch_prev[i])
                            || (i == 0 && hall_chg)) begin
                            st_next.cap[i] = st_reg.cnt; // RULE3
                            st_next.ev[i] = 1'b1;
                        end
                    end
                    mpct_pkg::MPCT_CH_COMPARE: begin
                        if (tick && st_reg.cnt == ch_compare[i]) begin
                            st_next.oc[i] = ~st_reg.oc[i]; // RULE3
                            st_next.ev[i] = 1'b1;
                        end
                    end
                    mpct_pkg::MPCT_CH_PWM: begin
                        // Compare 0 gives 0%, above reload gives 100%
                        st_next.oc[i] = (st_next.cnt < ch_compare[i]); // RULE5
                        st_next.ev[i] = tick && (st_reg.cnt == ch_compare[i]);
                    end
                    mpct_pkg::MPCT_CH_ONEPULSE: begin
                        if (st_next.upd) begin
                            st_next.op_done[i] = 1'b1;
                        end
                        st_next.oc[i] = !st_next.op_done[i]
                                        && (st_next.cnt >= ch_compare[i]); // RULE3
                    end
                    default: begin
                        st_next.oc[i] = 1'b0;
                        st_next.op_done[i] = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    logic [NCH-2:0] dt_hi;
    logic [NCH-2:0] dt_lo;
    genvar g;
    generate
        for (g = 0; g < NCH - 1; g++) begin : g_pair
            if (HAS_CMP) begin : g_dt
                mpct_deadtime #(.DT_W(DT_W)) u_dt (
                    .clk       (clk),
                    .rst_b     (rst_b),
                    .ce        (ce),
                    .ref_in    (st_reg.oc[g]),
                    .dead_time (dead_time),
                    .force_off (halted),
                    .out_hi    (dt_hi[g]),
                    .out_lo    (dt_lo[g])
                );
            end else begin : g_nodt
                assign dt_hi[g] = st_reg.oc[g];
                assign dt_lo[g] = 1'b0;
            end
        end
    endgenerate

    // Safe state under debug halt turns power switches off in the advanced variant only
    assign ch_out = {(HAS_CMP && halted) ? 1'b0 : st_reg.oc[NCH-1], dt_hi}; // RULE6
    assign ch_out_n      = dt_lo; // RULE4
    assign count         = st_reg.cnt;
    assign ch_captured   = st_reg.cap;
    assign ch_event      = st_reg.ev;
    assign update_event  = st_reg.upd; // RULE11
    assign dma_req       = st_reg.upd || (|st_reg.ev); // RULE8
    assign link_trig_out = st_reg.upd; // RULE7
    assign dac_trig      = st_reg.upd; // RULE10

    property p_halt_freeze;
        @(posedge clk) disable iff (!rst_b)
            (halted && ce && cnt_mode != mpct_pkg::MPCT_CNT_ENCODER) ##1 (halted && ce)
            |-> $stable(count);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("count moved in halt"); // RULE6

    property p_up_wrap;
        @(posedge clk) disable iff (!rst_b)
            (ce && tick && cnt_mode == mpct_pkg::MPCT_CNT_UP && at_top)
            |=> (count == C0 && update_event);
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("no reload on overflow"); // RULE11

    property p_down_wrap;
        @(posedge clk) disable iff (!rst_b)
            (ce && tick && HAS_CH && cnt_mode == mpct_pkg::MPCT_CNT_DOWN && at_bot)
            |=> (count == $past(auto_reload) && update_event);
    endproperty
    a_down_wrap: assert property (p_down_wrap) else $error("no reload on underflow"); // RULE1

    property p_psc;
        @(posedge clk) disable iff (!rst_b)
            (ce && run && !link_clock_sel && st_reg.psc_cnt < prescale
             && cnt_mode != mpct_pkg::MPCT_CNT_ENCODER) |=> $stable(count);
    endproperty
    a_psc: assert property (p_psc) else $error("prescaler tick early"); // RULE2

    property p_pwm_zero;
        @(posedge clk) disable iff (!rst_b)
            (ce && HAS_CH && ch_mode[NCH-1] == mpct_pkg::MPCT_CH_PWM && ch_compare[NCH-1] == C0)
            |=> !ch_out[NCH-1];
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("0 percent duty not low"); // RULE5

    property p_capture;
        @(posedge clk) disable iff (!rst_b)
            (ce && HAS_CH && ch_mode[1] == mpct_pkg::MPCT_CH_CAPTURE
             && st_reg.ch_s2[1] && !st_reg.ch_prev[1])
            |=> (ch_event[1] && ch_captured[1] == $past(count));
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed"); // RULE3

    property p_dma;
        @(posedge clk) disable iff (!rst_b) update_event |-> dma_req;
    endproperty
    a_dma: assert property (p_dma) else $error("no dma on update"); // RULE8

    property p_link_out;
        @(posedge clk) disable iff (!rst_b) update_event |-> (link_trig_out && dac_trig);
    endproperty
    a_link_out: assert property (p_link_out) else $error("trigger out missing"); // RULE7

    property p_halt_safe;
        @(posedge clk) disable iff (!rst_b)
            (HAS_CMP && halted && ce) ##1 halted |-> (ch_out == '0 && ch_out_n == '0);
    endproperty
    a_halt_safe: assert property (p_halt_safe) else $error("outputs live in halt"); // RULE6

    c_update:  cover property (@(posedge clk) update_event);
    c_capture: cover property (@(posedge clk) |ch_event);
    c_halt:    cover property (@(posedge clk) halted ##1 halted);
    c_enc:     cover property (@(posedge clk) enc_mv && enc_dn);
endmodule

/* File: sim/mpct_drive_model.sv */
`timescale 1ns/100ps
module mpct_drive_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       enc_go,
    input  wire logic       enc_dir,
    input  wire logic       hall_go,
    input  wire logic [2:0] sw_hi,
    input  wire logic [2:0] sw_lo,
    input  wire logic [7:0] dead_time,
    output logic            enc_a,
    output logic            enc_b,
    output logic [2:0]      hall_in,
    output logic [7:0]      faults
);
    localparam logic [2:0] HSEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [1:0] ph;
    logic [2:0] hi_q;
    logic [2:0] lo_q;
    int         hidx;
    int         gap [3];
    // Gray steps: only one line moves per step
    assign enc_a = ph[1];
    assign enc_b = ph[1] ^ ph[0];
    assign hall_in = HSEQ[hidx];
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph <= 2'h0;
            hidx <= 0;
            faults <= 8'h00;
            hi_q <= 3'h0;
            lo_q <= 3'h0;
            gap <= '{256, 256, 256};
        end else begin
            if (enc_go) ph <= enc_dir ? ph + 2'h1 : ph - 2'h1;
            if (hall_go) hidx <= (hidx == 5) ? 0 : hidx + 1;
            hi_q <= sw_hi;
            lo_q <= sw_lo;
            // Shoot-through or a short gap would destroy a real bridge
            for (int i = 0; i < 3; i++) begin
                if ((sw_hi[i] && sw_lo[i]) || (((sw_hi[i] && !hi_q[i]) ||
                    (sw_lo[i] && !lo_q[i])) && gap[i] < int'(dead_time) + 1)) begin
                    faults <= faults + 8'h01;
                end
                gap[i] <= (sw_hi[i] || sw_lo[i]) ? 0 : gap[i] + 1;
            end
        end
    end
endmodule

/* File: sim/mpct_timer_tb_top.sv */
`timescale 1ns/100ps
module mpct_timer_tb_top;
    logic                          clk, rst_b, ce, cnt_enable, dbg_halt, dbg_freeze_en;
    logic                          link_trig_in, link_clock_sel, link_start_sel, hall_sel;
    logic                          enc_a, enc_b, enc_go, enc_dir, hall_go, ok;
    mpct_pkg::mpct_cnt_mode_t      cnt_mode;
    mpct_pkg::mpct_ch_mode_t [3:0] ch_mode;
    logic [15:0]                   auto_reload, prescale, count, count_b, v;
    logic [3:0][15:0]              ch_compare, ch_captured;
    logic [3:0]                    ch_pin_in, ch_event, ch_out;
    logic [2:0]                    ch_out_n, hall_in;
    logic [7:0]                    dead_time, faults;
    logic                          update_event, dma_req, link_trig_out, dac_trig;
    logic [10:0]                   obs;
    logic [31:0]                   seed;
    int                            err_count, total_checks, p, r, c, n, h;
    int                            cv [3];
    assign obs = {ch_event, ch_out_n, ch_out};

    mpct_timer DUT (
        .clk(clk), .rst_b(rst_b), .ce(ce), .cnt_enable(cnt_enable), .cnt_mode(cnt_mode),
        .auto_reload(auto_reload), .prescale(prescale), .ch_mode(ch_mode),
        .ch_compare(ch_compare), .ch_pin_in(ch_pin_in), .dead_time(dead_time),
        .dbg_halt(dbg_halt), .dbg_freeze_en(dbg_freeze_en), .link_trig_in(link_trig_in),
        .link_clock_sel(link_clock_sel), .link_start_sel(link_start_sel), .enc_a(enc_a),
        .enc_b(enc_b), .hall_in(hall_in), .hall_sel(hall_sel), .count(count),
        .ch_captured(ch_captured), .ch_event(ch_event), .ch_out(ch_out),
        .ch_out_n(ch_out_n), .update_event(update_event), .dma_req(dma_req),
        .link_trig_out(link_trig_out), .dac_trig(dac_trig));
    mpct_timer #(.VARIANT(mpct_pkg::MPCT_VAR_BASIC)) dut_basic (
        .clk(clk), .rst_b(rst_b), .ce(ce), .cnt_enable(cnt_enable), .cnt_mode(cnt_mode),
        .auto_reload(auto_reload), .prescale(prescale), .ch_mode(ch_mode),
        .ch_compare(ch_compare), .ch_pin_in(ch_pin_in), .dead_time(dead_time),
        .dbg_halt(dbg_halt), .dbg_freeze_en(dbg_freeze_en), .link_trig_in(link_trig_in),
        .link_clock_sel(link_clock_sel), .link_start_sel(link_start_sel), .enc_a(enc_a),
        .enc_b(enc_b), .hall_in(hall_in), .hall_sel(hall_sel), .count(count_b),
        .ch_captured(), .ch_event(), .ch_out(), .ch_out_n(), .update_event(),
        .dma_req(), .link_trig_out(), .dac_trig());
    mpct_drive_model model (
        .clk(clk), .rst_b(rst_b), .enc_go(enc_go), .enc_dir(enc_dir), .hall_go(hall_go),
        .sw_hi(ch_out[2:0]), .sw_lo(ch_out_n), .dead_time(dead_time), .enc_a(enc_a),
        .enc_b(enc_b), .hall_in(hall_in), .faults(faults));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Centre mode updates at top and bottom, so half the span
    function automatic int exp_period(input int m, input int pp, input int rr);
        return (m == 2) ? (pp + 1) * rr : (pp + 1) * (rr + 1);
    endfunction
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        cyc(10);
        rst_b <= 1'b1;
    endtask
    task automatic cfg(input int m, input int pp, input int rr);
        cnt_mode <= mpct_pkg::mpct_cnt_mode_t'(m);
        prescale <= 16'(pp);
        auto_reload <= 16'(rr);
        do_reset();
    endtask
    task automatic wait_upd();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (update_event !== 1'b1 && k < 5000);
    endtask
    task automatic wait_ev(input int i, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ch_event[i] !== 1'b1 && k < 20);
    endtask
    task automatic cnt_hi(input int sel, input int len, output int hh);
        hh = 0;
        repeat (len) begin
            @(posedge clk);
            if (obs[sel] === 1'b1) hh++;
        end
    endtask
    task automatic pulse(input int k);
        if (k == 0) enc_go <= 1'b1;
        else link_trig_in <= 1'b1;
        @(posedge clk);
        enc_go <= 1'b0;
        link_trig_in <= 1'b0;
        cyc(5);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        cyc(20000);
        err_count++;
        finish_test();
    end
    initial begin
        seed = 32'h00000037;
        {err_count, total_checks} = '0;
        {rst_b, dbg_halt, dbg_freeze_en, link_trig_in, link_clock_sel, link_start_sel} = '0;
        {hall_sel, enc_go, enc_dir, hall_go, ch_pin_in, ch_compare} = '0;
        {ce, cnt_enable} = 2'h3;
        foreach (ch_mode[i]) ch_mode[i] = mpct_pkg::MPCT_CH_OFF;
        cnt_mode = mpct_pkg::MPCT_CNT_UP;
        {auto_reload, prescale, dead_time} = {16'h0002, 16'h0000, 8'h00};
        do_reset();
        wait_upd();
        chk("wrap count", 16'h0000, count);
        chk("dma req", 16'h0001, {15'h0000, dma_req});
        chk("link out", 16'h0001, {15'h0000, link_trig_out});
        chk("dac trig", 16'h0001, {15'h0000, dac_trig});
        @(posedge clk);
        chk("walk", 16'h0001, count);
        @(posedge clk);
        chk("walk", 16'h0002, count);
        for (int m = 0; m < 3; m++) begin
            p = 1 + rnd() % 4;
            r = 4 + rnd() % 16;
            cfg(m, p, r);
            wait_upd();
            cyc(1);
            wait_upd();
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (update_event !== 1'b1 && n < 5000);
            chk("period", 16'(exp_period(m, p, r)), 16'(n));
            if (m < 2) chk("reload", (m == 1) ? 16'(r) : 16'h0000, count);
            for (int k = 0; k < 12 && m == 1; k++) begin
                v = count_b;
                @(posedge clk);
                ok = count_b === v || count_b === v + 16'h0001 || count_b === 16'h0000;
                chk("basic up", 16'h0001, {15'h0000, ok});
            end
        end
        r = 8 + rnd() % 8;
        c = 1 + rnd() % r;
        dead_time <= 8'(rnd() % 3);
        cfg(0, 0, r);
        foreach (ch_mode[i]) ch_mode[i] <= mpct_pkg::MPCT_CH_PWM;
        for (int i = 0; i < 3; i++) ch_compare[i] <= 16'(r / 2);
        cv = '{0, c, r + 1};
        foreach (cv[i]) begin
            ch_compare[3] <= 16'(cv[i]);
            cyc(2 * (r + 1));
            cnt_hi(3, r + 1, h);
            chk("duty", 16'(cv[i]), 16'(h));
        end
        cnt_hi(0, r + 1, h);
        chk("dead hi", 16'(r / 2 - dead_time - 1), 16'(h));
        cnt_hi(4, r + 1, h);
        chk("dead lo", 16'(r + 1 - r / 2 - dead_time - 1), 16'(h));
        wait_upd();
        ch_mode[3] <= mpct_pkg::MPCT_CH_ONEPULSE;
        ch_compare[3] <= 16'(r - 2);
        @(posedge clk);
        cnt_hi(3, 3 * (r + 1), h);
        chk("one pulse", 16'h0003, 16'(h));
        ch_mode[1] <= mpct_pkg::MPCT_CH_COMPARE;
        ch_compare[1] <= 16'h0001;
        cyc(r + 2);
        cnt_hi(8, 4 * (r + 1), h);
        chk("compare events", 16'h0004, 16'(h));
        ch_mode[1] <= mpct_pkg::MPCT_CH_CAPTURE;
        ch_mode[0] <= mpct_pkg::MPCT_CH_CAPTURE;
        hall_sel <= 1'b1;
        cyc(4);
        ch_pin_in[1] <= 1'b1;
        wait_ev(1, n);
        chk("capture seen", 16'h0001, {15'h0000, n <= 4});
        chk("capture range", 16'h0001, {15'h0000, ch_captured[1] <= 16'(r)});
        ch_pin_in[1] <= 1'b0;
        hall_go <= 1'b1;
        @(posedge clk);
        hall_go <= 1'b0;
        wait_ev(0, n);
        chk("hall capture", 16'h0001, {15'h0000, n < 20});
        ch_mode[0] <= mpct_pkg::MPCT_CH_PWM;
        dbg_halt <= 1'b1;
        dbg_freeze_en <= 1'b1;
        cyc(4);
        v = count;
        repeat (8) begin
            @(posedge clk);
            chk("halt count", v, count);
            chk("halt outs", 16'h0000, {9'h000, ch_out_n, ch_out[2:0]});
        end
        dbg_freeze_en <= 1'b0;
        cyc(3);
        chk("no freeze", 16'h0001, {15'h0000, count !== v});
        dbg_halt <= 1'b0;
        ce <= 1'b0;
        cyc(2);
        v = count;
        cyc(5);
        chk("ce hold", v, count);
        ce <= 1'b1;
        cfg(3, 0, 16'h00FF);
        v = count;
        enc_dir <= 1'b1;
        repeat (8) pulse(0);
        chk("enc moved", 16'h0001, {15'h0000, count !== v});
        enc_dir <= 1'b0;
        repeat (8) pulse(0);
        chk("enc back", v, count);
        link_start_sel <= 1'b1;
        cfg(0, 0, 100);
        cyc(10);
        chk("wait start", 16'h0000, count);
        pulse(2);
        chk("started", 16'h0001, {15'h0000, count !== 16'h0000});
        link_start_sel <= 1'b0;
        link_clock_sel <= 1'b1;
        do_reset();
        repeat (5) pulse(2);
        chk("link ticks", 16'h0005, count);
        chk("switch faults", 16'h0000, {8'h00, faults});
        finish_test();
    end
endmodule
